// ==== inc/lie_pkg.sv ====
package lie_pkg;

  // Bus geometry
  localparam int          AXI_ADDR_W  = 8;
  localparam int          AXI_DATA_W  = 32;
  localparam int          AXI_STRB_W  = AXI_DATA_W / 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Register map (byte addresses)
  localparam logic [7:0] EVENT_SET_OFS   = 8'h80;
  localparam logic [7:0] EVENT_CLEAR_OFS = 8'h84;
  localparam logic [7:0] MASK_SET_OFS    = 8'h88;
  localparam logic [7:0] MASK_CLEAR_OFS  = 8'h8c;
  localparam logic [7:0] LINK_CTRL_OFS   = 8'h90;
  localparam logic [7:0] EVENT_RAW_OFS   = 8'h94;

  // Event bit positions
  localparam int SOFT_INT_BIT = 29;
  localparam int LATE_ACK_BIT = 27;
  localparam int PHY_REG_BIT  = 26;
  localparam int OVERLONG_BIT = 25;
  localparam int FATAL_BIT    = 24;
  localparam int MISMATCH_BIT = 23;

  // Link control bit positions
  localparam int LATE_ACK_EN_BIT  = 29;
  localparam int CYCLE_MASTER_BIT = 21;

  // Implemented bits and reset values
  localparam logic [31:0] EVENT_IMPL_MASK = 32'h2f80_0000;
  localparam logic [31:0] CTRL_IMPL_MASK  = 32'h2020_0000;
  localparam logic [31:0] EVENT_RESET     = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // Cycle timer field widths
  localparam int SECONDS_W = 7;
  localparam int COUNT_W   = 13;

  // Timing
  localparam int CLK_PERIOD_NS       = 4;
  localparam int OVERLONG_TIME_NS    = 125000;
  localparam int OVERLONG_CYCLES_DEF = OVERLONG_TIME_NS / CLK_PERIOD_NS;

  // Edge-detected source slots
  localparam int SRC_LATE_ACK = 0;
  localparam int SRC_PHY_REG  = 1;
  localparam int SRC_OVERLONG = 2;
  localparam int SRC_MISMATCH = 3;
  localparam int SRC_N        = 4;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'h1,
    TMR_RUN  = 2'h2
  } lie_tmr_e;

  // Write data restricted to the byte lanes that are strobed
  function automatic logic [31:0] lie_strobe_mask(input logic [31:0] data,
                                                  input logic [3:0]  strb);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : 8'h00;
    end
    return m;
  endfunction

  // Word-aligned address compare
  function automatic logic lie_addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction

endpackage

// ==== logic/lie_edge_detect.sv ====
`timescale 1ns/1ps
module lie_edge_detect #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Levels in, one-cycle rising edges out
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;

  always_comb begin
    prev_next = level;
    rise      = level & ~prev_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= prev_next;
    end
  end

endmodule

// ==== logic/lie_axil_slave.sv ====
`timescale 1ns/1ps
module lie_axil_slave
  import lie_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write address and data
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
  // Write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // Read address and data
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Register-side strobes
  output logic                       wr_en,
  output logic [AXI_ADDR_W-1:0]      wr_addr,
  output logic [AXI_DATA_W-1:0]      wr_data,
  output logic [AXI_STRB_W-1:0]      wr_strb,
  input  wire logic                  wr_ok,
  output logic                       rd_en,
  output logic [AXI_ADDR_W-1:0]      rd_addr,
  input  wire logic [AXI_DATA_W-1:0] rd_data,
  input  wire logic                  rd_ok
);

  logic                  aw_held_reg, aw_held_next;
  logic [AXI_ADDR_W-1:0] awaddr_reg,  awaddr_next;
  logic                  w_held_reg,  w_held_next;
  logic [AXI_DATA_W-1:0] wdata_reg,   wdata_next;
  logic [AXI_STRB_W-1:0] wstrb_reg,   wstrb_next;
  logic                  bvalid_reg,  bvalid_next;
  logic [1:0]            bresp_reg,   bresp_next;
  logic                  rvalid_reg,  rvalid_next;
  logic [AXI_DATA_W-1:0] rdata_reg,   rdata_next;
  logic [1:0]            rresp_reg,   rresp_next;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign wr_addr       = awaddr_reg;
  assign wr_data       = wdata_reg;
  assign wr_strb       = wstrb_reg;
  assign rd_addr       = s_axi_araddr;

  // Address and data are held separately; the write fires once both are in
  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next  = awaddr_reg;
    w_held_next  = w_held_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    wr_en        = aw_held_reg && w_held_reg && !bvalid_reg;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_en) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read data are captured on the address handshake
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    rd_en       = s_axi_arvalid && !rvalid_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_en) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_data;
      rresp_next  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_held_reg  <= 1'b0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      awaddr_reg  <= awaddr_next;
      w_held_reg  <= w_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

endmodule

// ==== logic/lie_event_latch.sv ====
`timescale 1ns/1ps
// Operation
// - Source edge or set-address write sets bit
// - Only write-one at clear address clears
// - Event set/clear reads return events ANDed with mask
// - Bits 31 and 30 read zero
// - Bit 28 reads zero
// - Bit 29 is software-only interrupt source
// - Late-ack conditions set bit 27 when enabled
// - PHY register byte arrival sets bit 26
// - Cycle master overrun past 125 us sets 25
// - Overrun also clears cycle master enable
// - Subunit-stopping error sets bit 24
// - Bit 24 blocks offending contexts' events
// - Received cycle time mismatch sets bit 23
module lie_event_latch
  import lie_pkg::*;
#(
  parameter int OVERLONG_CYCLES = OVERLONG_CYCLES_DEF,
  parameter int CTX_N           = 4
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Late acknowledge conditions
  input  wire logic                  rx_fifo_pending,
  input  wire logic                  phys_resp_busy,
  input  wire logic                  ack_tardy_sent,
  // PHY register byte arrival
  input  wire logic                  phy_reg_byte_received,
  // Cycle master timing
  input  wire logic                  cycle_start_tx_begin,
  input  wire logic                  subaction_gap_end,
  // Received cycle start check
  input  wire logic                  cycle_start_rx,
  input  wire logic [SECONDS_W-1:0]  rx_cycle_seconds,
  input  wire logic [COUNT_W-1:0]    rx_cycle_count,
  input  wire logic [SECONDS_W-1:0]  cycle_seconds_field,
  input  wire logic [COUNT_W-1:0]    cycle_count_field,
  // Context errors
  input  wire logic [CTX_N-1:0]      ctx_dead,
  output logic [CTX_N-1:0]           ctx_event_block,
  // Control outputs and interrupt
  output logic                       late_ack_event_enable,
  output logic                       cycle_master_enable,
  output logic                       irq
);

  localparam int SRC_W = SRC_N + CTX_N;
  localparam int CNT_W = $clog2(OVERLONG_CYCLES + 1);

  logic                  wr_en, wr_ok, rd_en, rd_ok;
  logic [AXI_ADDR_W-1:0] wr_addr, rd_addr;
  logic [AXI_DATA_W-1:0] wr_data, rd_data;
  logic [AXI_STRB_W-1:0] wr_strb;
  logic [31:0]           wr_mask, set_sw, clr_sw, ev_hw, gated_events;
  logic [31:0]           event_reg, event_next;
  logic [31:0]           mask_reg, mask_next;
  logic [31:0]           ctrl_reg, ctrl_next;
  logic [CTX_N-1:0]      dead_cause_reg, dead_cause_next;
  logic [SRC_W-1:0]      src_level, src_rise;
  logic [CTX_N-1:0]      ctx_rise;
  logic                  late_ack_level, mismatch_level, overlong_hit;
  lie_tmr_e              tmr_state_reg, tmr_state_next;
  logic [CNT_W-1:0]      tmr_cnt_reg, tmr_cnt_next;

  lie_axil_slave u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // Source levels; each event latches on the rising edge of its level
  assign late_ack_level = late_ack_event_enable
                          & (rx_fifo_pending | phys_resp_busy | ack_tardy_sent);
  assign mismatch_level = cycle_start_rx && ((rx_cycle_seconds != cycle_seconds_field)
                          || (rx_cycle_count != cycle_count_field));
  assign src_level = {ctx_dead, mismatch_level, overlong_hit,
                      phy_reg_byte_received, late_ack_level};
  assign ctx_rise  = src_rise[SRC_W-1:SRC_N];

  lie_edge_detect #(
    .W (SRC_W)
  ) u_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (src_level),
    .rise    (src_rise)
  );

  // Write decode
  always_comb begin
    wr_mask = lie_strobe_mask(wr_data, wr_strb);
    set_sw  = (wr_en && lie_addr_hit(wr_addr, EVENT_SET_OFS))   ? wr_mask : 32'h0;
    clr_sw  = (wr_en && lie_addr_hit(wr_addr, EVENT_CLEAR_OFS)) ? wr_mask : 32'h0;
    wr_ok   = lie_addr_hit(wr_addr, EVENT_SET_OFS) || lie_addr_hit(wr_addr, EVENT_CLEAR_OFS)
           || lie_addr_hit(wr_addr, MASK_SET_OFS) || lie_addr_hit(wr_addr, MASK_CLEAR_OFS)
           || lie_addr_hit(wr_addr, LINK_CTRL_OFS) || lie_addr_hit(wr_addr, EVENT_RAW_OFS);
  end

  // Event, mask, control and dead-context state
  always_comb begin
    ev_hw               = 32'h0;
    ev_hw[LATE_ACK_BIT] = src_rise[SRC_LATE_ACK];
    ev_hw[PHY_REG_BIT]  = src_rise[SRC_PHY_REG];
    ev_hw[OVERLONG_BIT] = src_rise[SRC_OVERLONG];
    ev_hw[FATAL_BIT]    = |ctx_rise;
    ev_hw[MISMATCH_BIT] = src_rise[SRC_MISMATCH];
    // A set in the same cycle as a clear wins
    event_next = ((event_reg & ~clr_sw) | ev_hw | set_sw) & EVENT_IMPL_MASK;
    mask_next  = mask_reg;
    if (wr_en && lie_addr_hit(wr_addr, MASK_SET_OFS)) begin
      mask_next = (mask_reg | wr_mask) & EVENT_IMPL_MASK;
    end
    if (wr_en && lie_addr_hit(wr_addr, MASK_CLEAR_OFS)) begin
      mask_next = mask_reg & ~wr_mask;
    end
    ctrl_next = ctrl_reg;
    if (wr_en && lie_addr_hit(wr_addr, LINK_CTRL_OFS)) begin
      ctrl_next = ((ctrl_reg & ~lie_strobe_mask(32'hffff_ffff, wr_strb))
                   | wr_mask) & CTRL_IMPL_MASK;
    end
    if (overlong_hit) begin
      ctrl_next[CYCLE_MASTER_BIT] = 1'b0;
    end
    dead_cause_next = event_next[FATAL_BIT] ? (dead_cause_reg | ctx_rise) : '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_reg      <= EVENT_RESET;
      mask_reg       <= MASK_RESET;
      ctrl_reg       <= CTRL_RESET;
      dead_cause_reg <= '0;
    end else begin
      event_reg      <= event_next;
      mask_reg       <= mask_next;
      ctrl_reg       <= ctrl_next;
      dead_cause_reg <= dead_cause_next;
    end
  end

  assign late_ack_event_enable = ctrl_reg[LATE_ACK_EN_BIT];
  assign cycle_master_enable   = ctrl_reg[CYCLE_MASTER_BIT];
  assign ctx_event_block       = {CTX_N{event_reg[FATAL_BIT]}} & dead_cause_reg;
  assign gated_events          = event_reg & mask_reg & EVENT_IMPL_MASK;
  assign irq                   = |gated_events;

  // Read decode
  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    if (lie_addr_hit(rd_addr, EVENT_SET_OFS) || lie_addr_hit(rd_addr, EVENT_CLEAR_OFS)) begin
      rd_data = gated_events;
    end else if (lie_addr_hit(rd_addr, MASK_SET_OFS)
                 || lie_addr_hit(rd_addr, MASK_CLEAR_OFS)) begin
      rd_data = mask_reg;
    end else if (lie_addr_hit(rd_addr, LINK_CTRL_OFS)) begin
      rd_data = ctrl_reg;
    end else if (lie_addr_hit(rd_addr, EVENT_RAW_OFS)) begin
      rd_data = event_reg;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Cycle master watchdog: from cycle start transmit to the next subaction gap end
  always_comb begin
    tmr_state_next = tmr_state_reg;
    tmr_cnt_next   = tmr_cnt_reg;
    overlong_hit   = 1'b0;
    case (tmr_state_reg)
      TMR_IDLE: begin
        if (cycle_master_enable && cycle_start_tx_begin) begin
          tmr_state_next = TMR_RUN;
          tmr_cnt_next   = '0;
        end
      end
      TMR_RUN: begin
        tmr_cnt_next = tmr_cnt_reg + 1'b1;
        if (!cycle_master_enable || subaction_gap_end) begin
          tmr_state_next = TMR_IDLE;
        end else if (tmr_cnt_reg == CNT_W'(OVERLONG_CYCLES)) begin
          overlong_hit   = 1'b1;
          tmr_state_next = TMR_IDLE;
        end
      end
      default: begin
        tmr_state_next = TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_state_reg <= TMR_IDLE;
      tmr_cnt_reg   <= '0;
    end else begin
      tmr_state_reg <= tmr_state_next;
      tmr_cnt_reg   <= tmr_cnt_next;
    end
  end

  sw_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    set_sw[SOFT_INT_BIT] |=> event_reg[SOFT_INT_BIT])
    else $error("set-address write did not set software bit");

  clear_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    event_reg[FATAL_BIT] && !clr_sw[FATAL_BIT] |=> event_reg[FATAL_BIT])
    else $error("event bit cleared without clear write");

  read_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_en && lie_addr_hit(rd_addr, EVENT_CLEAR_OFS)
    |=> s_axi_rdata == ($past(event_reg) & $past(mask_reg)))
    else $error("event read not gated by mask");

  rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_en && lie_addr_hit(rd_addr, EVENT_SET_OFS)
    |=> s_axi_rdata[31:30] == 2'h0 && !s_axi_rdata[28])
    else $error("reserved event bits read nonzero");

  soft_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !event_reg[SOFT_INT_BIT] && !set_sw[SOFT_INT_BIT] |=> !event_reg[SOFT_INT_BIT])
    else $error("software bit set by hardware");

  late_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(event_reg[LATE_ACK_BIT])
    |-> $past(late_ack_event_enable) || $past(set_sw[LATE_ACK_BIT]))
    else $error("late-ack event while disabled");

  phy_reg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(phy_reg_byte_received) |=> event_reg[PHY_REG_BIT])
    else $error("PHY register arrival not latched");

  overlong_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overlong_hit |=> event_reg[OVERLONG_BIT] && !cycle_master_enable)
    else $error("overrun did not latch or stop cycle master");

  overlong_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    overlong_hit |-> tmr_cnt_reg == CNT_W'(OVERLONG_CYCLES) && !subaction_gap_end)
    else $error("overrun flagged at wrong time");

  fatal_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |ctx_rise |=> event_reg[FATAL_BIT]
    && ((ctx_event_block & $past(ctx_rise)) == $past(ctx_rise)))
    else $error("dead context not latched or not blocked");

  mismatch_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mismatch_level && !$past(mismatch_level) |=> event_reg[MISMATCH_BIT])
    else $error("cycle time mismatch not latched");

  irq_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    set_sw[PHY_REG_BIT] && mask_reg[PHY_REG_BIT] |=> irq)
    else $error("interrupt not raised for unmasked event");

endmodule

// ==== tb/tb_lie_event_latch.sv ====
`timescale 1ns/1ps
module tb_lie_event_latch;
  import lie_pkg::*;
  localparam int OVL = 20;
  logic        aclk, aresetn;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, ctx_dead, ctx_blk;
  logic [1:0]  bresp, rresp;
  logic        fifo_pend, pru_busy, tardy, phy_rx, cs_tx, gap_end, cs_rx;
  logic [6:0]  rx_sec, loc_sec;
  logic [12:0] rx_cnt, loc_cnt;
  logic        la_en, cm_en, irq;
  int          num_errors, checks_done;

  lie_event_latch #(.OVERLONG_CYCLES(OVL), .CTX_N(4)) i_lie_event_latch (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .rx_fifo_pending(fifo_pend), .phys_resp_busy(pru_busy), .ack_tardy_sent(tardy),
    .phy_reg_byte_received(phy_rx), .cycle_start_tx_begin(cs_tx),
    .subaction_gap_end(gap_end), .cycle_start_rx(cs_rx),
    .rx_cycle_seconds(rx_sec), .rx_cycle_count(rx_cnt),
    .cycle_seconds_field(loc_sec), .cycle_count_field(loc_cnt),
    .ctx_dead(ctx_dead), .ctx_event_block(ctx_blk),
    .late_ack_event_enable(la_en), .cycle_master_enable(cm_en), .irq(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ready and answer are sampled mid-cycle; the handshake is the following rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_h, w_h, b_h;
    logic [1:0] rs;
    b_h = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_h) begin
      @(negedge aclk);
      aw_h = awvalid && awready;
      w_h = wvalid && wready;
      b_h = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw_h) awvalid <= 1'b0;
      if (w_h) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
    check(32'(rs), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_h, r_h;
    logic [31:0] d;
    logic [1:0] rs;
    r_h = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_h) begin
      @(negedge aclk);
      ar_h = arvalid && arready;
      r_h = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar_h) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
    check(d, ed);
    check(32'(rs), 32'(er));
  endtask

  task automatic t_soft();
    rd(EVENT_SET_OFS, 32'h0, RESP_OKAY);
    wr(MASK_SET_OFS, 32'hffff_ffff, RESP_OKAY);
    wr(EVENT_SET_OFS, 32'hffff_ffff, RESP_OKAY);
    rd(EVENT_CLEAR_OFS, 32'h2f80_0000, RESP_OKAY);
    check(32'(irq), 32'h1);
    wr(EVENT_CLEAR_OFS, 32'h0, RESP_OKAY);
    rd(EVENT_SET_OFS, 32'h2f80_0000, RESP_OKAY);
    wr(EVENT_CLEAR_OFS, 32'h2000_0000, RESP_OKAY);
    rd(EVENT_SET_OFS, 32'h0f80_0000, RESP_OKAY);
    wr(EVENT_CLEAR_OFS, 32'hffff_ffff, RESP_OKAY);
    @(negedge aclk);
    check(32'(irq), 32'h0);
    @(posedge aclk);
    wr(MASK_CLEAR_OFS, 32'h2000_0000, RESP_OKAY);
    wr(EVENT_SET_OFS, 32'h2000_0000, RESP_OKAY);
    rd(EVENT_SET_OFS, 32'h0, RESP_OKAY);
    rd(EVENT_RAW_OFS, 32'h2000_0000, RESP_OKAY);
    check(32'(irq), 32'h0);
    wr(MASK_SET_OFS, 32'h2000_0000, RESP_OKAY);
    @(negedge aclk);
    check(32'(irq), 32'h1);
    @(posedge aclk);
    wr(EVENT_CLEAR_OFS, 32'h2000_0000, RESP_OKAY);
    wr(8'h40, 32'hffff_ffff, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
  endtask

  task automatic t_late();
    fifo_pend <= 1'b1;
    repeat (2) @(posedge aclk);
    fifo_pend <= 1'b0;
    rd(EVENT_RAW_OFS, 32'h0, RESP_OKAY);
    wr(LINK_CTRL_OFS, 32'h2000_0000, RESP_OKAY);
    check(32'(la_en), 32'h1);
    for (int k = 0; k < 3; k++) begin
      {fifo_pend, pru_busy, tardy} <= 3'h4 >> k;
      repeat (2) @(posedge aclk);
      {fifo_pend, pru_busy, tardy} <= 3'h0;
      rd(EVENT_SET_OFS, 32'h0800_0000, RESP_OKAY);
      wr(EVENT_CLEAR_OFS, 32'h0800_0000, RESP_OKAY);
    end
    phy_rx <= 1'b1;
    @(posedge aclk);
    phy_rx <= 1'b0;
    rd(EVENT_SET_OFS, 32'h0400_0000, RESP_OKAY);
    wr(EVENT_CLEAR_OFS, 32'h0400_0000, RESP_OKAY);
  endtask

  task automatic t_cycle();
    wr(LINK_CTRL_OFS, 32'h0020_0000, RESP_OKAY);
    cs_tx <= 1'b1;
    @(posedge aclk);
    cs_tx <= 1'b0;
    repeat (5) @(posedge aclk);
    gap_end <= 1'b1;
    @(posedge aclk);
    gap_end <= 1'b0;
    repeat (OVL + 10) @(posedge aclk);
    rd(EVENT_RAW_OFS, 32'h0, RESP_OKAY);
    check(32'(cm_en), 32'h1);
    cs_tx <= 1'b1;
    @(posedge aclk);
    cs_tx <= 1'b0;
    repeat (OVL) @(posedge aclk);
    @(negedge aclk);
    check(32'(irq), 32'h0);
    @(posedge aclk);
    @(negedge aclk);
    check(32'(irq), 32'h1);
    @(posedge aclk);
    rd(EVENT_SET_OFS, 32'h0200_0000, RESP_OKAY);
    check(32'(cm_en), 32'h0);
    rd(LINK_CTRL_OFS, 32'h0, RESP_OKAY);
    wr(EVENT_CLEAR_OFS, 32'h0200_0000, RESP_OKAY);
  endtask

  task automatic t_fatal_time();
    ctx_dead <= 4'h2;
    repeat (3) @(posedge aclk);
    rd(EVENT_SET_OFS, 32'h0100_0000, RESP_OKAY);
    check(32'(ctx_blk), 32'h2);
    ctx_dead <= 4'h0;
    wr(EVENT_CLEAR_OFS, 32'h0100_0000, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(ctx_blk), 32'h0);
    for (int k = 0; k < 3; k++) begin
      rx_sec <= (k == 1) ? 7'h06 : 7'h05;
      rx_cnt <= (k == 2) ? 13'h0124 : 13'h0123;
      @(posedge aclk);
      cs_rx <= 1'b1;
      @(posedge aclk);
      cs_rx <= 1'b0;
      rd(EVENT_RAW_OFS, (k == 0) ? 32'h0 : 32'h0080_0000, RESP_OKAY);
      wr(EVENT_CLEAR_OFS, 32'h0080_0000, RESP_OKAY);
    end
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {fifo_pend, pru_busy, tardy, phy_rx, cs_tx, gap_end, cs_rx} = 7'h0;
    {awaddr, araddr, wdata, wstrb, ctx_dead} = 56'h0;
    {rx_sec, loc_sec} = {7'h05, 7'h05};
    {rx_cnt, loc_cnt} = {13'h0123, 13'h0123};
    num_errors = 0;
    checks_done = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_soft();
    t_late();
    t_cycle();
    t_fatal_time();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    summarize();
  end
endmodule
